// ### include/evpu_pkg.sv
/*
 * Shared constants of the exception vector priority unit: register word
 * indices, field positions, reset values and the request index map.
 * Assumes a 32-bit AHB-Lite register bus and 16-bit vector addresses of
 * the form 0xFFxx, where a source index is the low vector byte over two.
 */
package evpu_pkg;

  // ************************************************************
  // register word indices (byte address is four times the index)
  // ************************************************************
  localparam logic [5:0] REG_IDX_TEST_CTRL = 6'h15;
  localparam logic [5:0] REG_IDX_TEST_DATA = 6'h16;
  localparam logic [5:0] REG_IDX_PROMOTE = 6'h1F;
  localparam logic [5:0] REG_IDX_IRQ_STATUS = 6'h20;
  localparam logic [5:0] REG_IDX_IRQ_CLEAR = 6'h21;
  localparam logic [5:0] REG_IDX_IRQ_ENABLE = 6'h22;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int TEST_WEN_BIT = 4;
  localparam logic [3:0] TEST_ADR_RST = 4'h0;
  localparam logic [7:0] PROMOTE_RST = 8'hF2;
  localparam logic [3:0] TEST_ADR_TOP = 4'hF;
  localparam logic [7:0] TEST_TOP_MASK = 8'h07;
  localparam int ST_BITS = 3;
  localparam int ST_VEC_DONE = 0;
  localparam int ST_PROM_REFUSED = 1;
  localparam int ST_FALLBACK = 2;
  localparam logic [ST_BITS-1:0] ST_RST = 3'h0;

  // ************************************************************
  // source indices, highest priority last
  // ************************************************************
  localparam int NUM_SRC = 128;
  localparam int NUM_PERIPH = 121;
  localparam int NUM_TESTABLE = 123;
  localparam logic [6:0] IDX_IRQ = 7'h79;
  localparam logic [6:0] IDX_NONMASKABLE_EXTERNAL_REQUEST = 7'h7A;
  localparam logic [6:0] IDX_SWI = 7'h7B;
  localparam logic [6:0] IDX_TRAP = 7'h7C;
  localparam logic [6:0] IDX_WDOG = 7'h7D;
  localparam logic [6:0] IDX_OSC = 7'h7E;
  localparam logic [6:0] IDX_SYS = 7'h7F;
  localparam logic [6:0] IDX_RTI = 7'h38;
  localparam logic [7:0] VEC_PAGE = 8'hFF;

  // ************************************************************
  // helpers
  // ************************************************************
  // vector address of a source index
  function automatic logic [15:0] evpu_vec_addr(input logic [6:0] idx);
    evpu_vec_addr = {VEC_PAGE, idx, 1'b0};
  endfunction : evpu_vec_addr

endpackage : evpu_pkg

// ### include/evpu_req_if.sv
/*
 * Carrier between the unit top and its priority decoder: the request
 * vector and masks going in, the winning source coming back.
 * Assumes both ends sit on the same clock; the decoder is combinational.
 */
`timescale 1ns/10ps
interface evpu_req_if;
  logic [127:0] req;
  logic imask;
  logic xmask;
  logic [6:0] prom;
  logic found;
  logic [6:0] idx;

  modport decoder (input req, input imask, input xmask, input prom,
                   output found, output idx);
  modport source (output req, output imask, output xmask, output prom,
                  input found, input idx);
endinterface : evpu_req_if

// ### logic/evpu_prio.sv
/*
 * Combinational priority decoder of the exception vector unit.
 * Assumes the request vector is indexed by low vector byte over two and
 * that the promoted index has already been range-checked by the top.
 */
`timescale 1ns/10ps
module evpu_prio
  import evpu_pkg::*;
(
  evpu_req_if.decoder rq
);

  // slot owner: promoted source and the tick source trade places
  function automatic logic [6:0] slot_src(input logic [6:0] s,
                                          input logic [6:0] prom);
    slot_src = s;
    if (prom != IDX_IRQ) begin
      if (s == prom) begin
        slot_src = IDX_RTI;
      end else if (s == IDX_RTI) begin
        slot_src = prom;
      end
    end
  endfunction : slot_src

  // later hits overwrite earlier ones, so the highest wins
  always_comb begin
    logic [6:0] src;
    src = 7'h00;
    rq.found = 1'b0;
    rq.idx = 7'h00;
    for (int i = 0; i <= int'(IDX_IRQ); i++) begin
      src = slot_src(7'(i), rq.prom);
      if (rq.req[src] && !rq.imask) begin
        rq.found = 1'b1;
        rq.idx = src;
      end
    end
    if (rq.req[rq.prom] && !rq.imask) begin
      rq.found = 1'b1;
      rq.idx = rq.prom;
    end
    if (rq.req[IDX_NONMASKABLE_EXTERNAL_REQUEST] && !rq.xmask) begin
      rq.found = 1'b1;
      rq.idx = IDX_NONMASKABLE_EXTERNAL_REQUEST;
    end
    for (int i = int'(IDX_SWI); i < NUM_SRC; i++) begin
      if (rq.req[i]) begin
        rq.found = 1'b1;
        rq.idx = 7'(i);
      end
    end
  end

endmodule : evpu_prio

// ### logic/evpu_sync.sv
/*
 * Three-stage input synchroniser with agreement filter for pin inputs.
 * Assumes pins are asynchronous to CLK_I; the output follows only when
 * the second and third stages agree.
 */
`timescale 1ns/10ps
module evpu_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] st1_reg;
  logic [WIDTH-1:0] st2_reg;
  logic [WIDTH-1:0] st3_reg;

  // shift chain, first stage read only by the second
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st1_reg <= RST_VAL;
      st2_reg <= RST_VAL;
      st3_reg <= RST_VAL;
    end else begin
      st1_reg <= pin_i;
      st2_reg <= st1_reg;
      st3_reg <= st2_reg;
    end
  end

  // accept a bit once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      level_o <= RST_VAL;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (st2_reg[i] == st3_reg[i]) begin
          level_o[i] <= st3_reg[i];
        end
      end
    end
  end

endmodule : evpu_sync

// ### logic/evpu_top.sv
/*
 * Exception vector priority unit: gathers reset, trap, software,
 * non-maskable and maskable requests and answers CPU vector requests,
 * with a promotion register, test registers and an event interrupt.
 * Assumes one 40 MHz clock, synchronous reset, an AHB-Lite master and
 * peripheral requests that are already synchronous to CLK_I.
 */
`timescale 1ns/10ps

// Behaviour
// - a 7-bit promotion field in bits 7:1 picks the maskable source raised to the top of the maskable group.
// - a promotion value above the maskable range makes the external maskable line the promoted one.
// - the promotion register reads at any time and a write counts only while the CPU maskable mask is 1.
// - the promoted source's vector goes to the decoder whenever that source is active.
// - the real-time tick source takes the priority slot that the promoted source left.
// - an asynchronous wake-up rises on any valid interrupt or any non-maskable pin request.
// - the system reports one of three reset kinds and the unit returns its reset vector.
// - the vector is chosen when the CPU asks, so a newer higher request wins.
// - when the live source vanished the vector of the last valid request is returned.
// - when nothing was ever pending the software trap vector is returned.
// - system reset, oscillator monitor reset and watchdog reset come first at the top three words.
// - the opcode trap follows, then one shared software trap and debug vector.
// - non-maskable pin, maskable pin, then peripherals from high to low address.
// - test data is usable only in special modes and reads zero otherwise; the test control word reads and takes its select in any mode.
// - with the test write enable set the decoder sees the test register values.
module evpu_top
  import evpu_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic RST_SYS_I,
  input wire logic RST_OSC_I,
  input wire logic RST_WDOG_I,
  input wire logic TRAP_I,
  input wire logic SWI_I,
  input wire logic NMI_N_I,
  input wire logic IRQ_N_I,
  input wire logic [120:0] PERIPH_REQ_I,
  input wire logic IMASK_I,
  input wire logic XMASK_I,
  input wire logic SPECIAL_MODE_I,
  input wire logic VEC_REQ_I,
  output logic [15:0] VEC_O,
  output logic VEC_VALID_O,
  output logic WAKEUP_O,
  output logic IRQ_O
);

  // ************************************************************
  // declarations
  // ************************************************************
  evpu_req_if rq ();
  logic [1:0] pin_lvl;
  logic [127:0] raw_req;
  logic [NUM_TESTABLE-1:0] test_flat;
  logic [7:0] test_mem [0:15];
  logic [3:0] test_adr_reg;
  logic test_wen_reg;
  logic [7:0] prom_reg;
  logic [6:0] prom_eff;
  logic [ST_BITS-1:0] st_reg;
  logic [ST_BITS-1:0] en_reg;
  logic [ST_BITS-1:0] st_set;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [5:0] addr_reg;
  logic addr_ok;
  logic wr_strb;
  logic [31:0] rd_next;
  logic busy_reg;
  logic vec_take;
  logic ever_reg;
  logic [6:0] last_reg;
  logic [15:0] sel_vec;

  // ************************************************************
  // pin synchronisers and request vector
  // ************************************************************
  evpu_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_sync (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .pin_i({NMI_N_I, IRQ_N_I}),
    .level_o(pin_lvl)
  );

  // index equals low vector byte over two
  assign raw_req = {RST_SYS_I, RST_OSC_I, RST_WDOG_I, TRAP_I, SWI_I,
                    ~pin_lvl[1], ~pin_lvl[0], PERIPH_REQ_I};

  // flatten test storage onto the testable indices
  always_comb begin
    test_flat = '0;
    for (int i = 0; i < NUM_TESTABLE; i++) begin
      test_flat[i] = test_mem[i / 8][i % 8];
    end
  end

  // decoder input: real requests or test values
  assign rq.req = test_wen_reg ?
                  {raw_req[127:NUM_TESTABLE], test_flat} : raw_req;
  assign rq.imask = IMASK_I;
  assign rq.xmask = XMASK_I;
  assign rq.prom = prom_eff;

  // out-of-range promotion falls back to the maskable pin
  assign prom_eff = (prom_reg[7:1] > IDX_IRQ) ?
                    IDX_IRQ : prom_reg[7:1];

  evpu_prio u_prio (
    .rq(rq.decoder)
  );

  // ************************************************************
  // wake-up path
  // ************************************************************
  // unclocked on purpose: clocks may be stopped in wait and stop
  assign WAKEUP_O = ~NMI_N_I | ((~IRQ_N_I | (|PERIPH_REQ_I)) & ~IMASK_I)
                    | TRAP_I | SWI_I;

  // ************************************************************
  // vector request handling
  // ************************************************************
  assign vec_take = VEC_REQ_I && !busy_reg;

  // live winner, else last valid, else software trap vector
  always_comb begin
    if (rq.found) begin
      sel_vec = evpu_vec_addr(rq.idx);
    end else if (ever_reg) begin
      sel_vec = evpu_vec_addr(last_reg);
    end else begin
      sel_vec = evpu_vec_addr(IDX_SWI);
    end
  end

  // remember the last valid winner of the sequence
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ever_reg <= 1'b0;
      last_reg <= IDX_SWI;
    end else if (rq.found) begin
      ever_reg <= 1'b1;
      last_reg <= rq.idx;
    end
  end

  // latch the vector at the strobe, hold while it stays high
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      busy_reg <= 1'b0;
      VEC_O <= evpu_vec_addr(IDX_SWI);
      VEC_VALID_O <= 1'b0;
    end else begin
      busy_reg <= VEC_REQ_I;
      VEC_VALID_O <= VEC_REQ_I;
      if (vec_take) begin
        VEC_O <= sel_vec;
      end
    end
  end

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************
  assign addr_ok = HSEL_I && HTRANS_I[1] && HREADY_I;
  assign wr_strb = wr_pend_reg;

  // capture address phase; reads add one wait state
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 6'h00;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
      HRDATA_O <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= addr_ok && HWRITE_I;
      rd_pend_reg <= addr_ok && !HWRITE_I;
      HRESP_O <= 1'b0;
      if (addr_ok) begin
        addr_reg <= HADDR_I[7:2];
      end
      HREADYOUT_O <= !(addr_ok && !HWRITE_I);
      if (rd_pend_reg) begin
        HRDATA_O <= rd_next;
      end
    end
  end

  // read mux, unmapped words read zero
  always_comb begin
    rd_next = 32'h0000_0000;
    case (addr_reg)
      REG_IDX_TEST_CTRL: begin
        rd_next[TEST_WEN_BIT] = test_wen_reg;
        rd_next[3:0] = test_adr_reg;
      end
      REG_IDX_TEST_DATA: begin
        if (SPECIAL_MODE_I) begin
          rd_next[7:0] = test_wen_reg ? test_mem[test_adr_reg] :
                         raw_req[{test_adr_reg, 3'h0} +: 8];
          if (test_adr_reg == TEST_ADR_TOP) begin
            rd_next[7:0] = rd_next[7:0] & TEST_TOP_MASK;
          end
        end
      end
      REG_IDX_PROMOTE: rd_next[7:0] = {prom_reg[7:1], 1'b0};
      REG_IDX_IRQ_STATUS: rd_next[ST_BITS-1:0] = st_reg;
      REG_IDX_IRQ_ENABLE: rd_next[ST_BITS-1:0] = en_reg;
      default: rd_next = 32'h0000_0000;
    endcase
  end

  // ************************************************************
  // register writes
  // ************************************************************
  // promotion select, taken only under the maskable mask
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      prom_reg <= PROMOTE_RST;
    end else if (wr_strb && addr_reg == REG_IDX_PROMOTE && IMASK_I) begin
      prom_reg <= {HWDATA_I[7:1], 1'b0};
    end
  end

  // test control: select anytime, enable in special mode under masks
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      test_adr_reg <= TEST_ADR_RST;
      test_wen_reg <= 1'b0;
    end else if (wr_strb && addr_reg == REG_IDX_TEST_CTRL) begin
      test_adr_reg <= HWDATA_I[3:0];
      if (SPECIAL_MODE_I && IMASK_I && XMASK_I) begin
        test_wen_reg <= HWDATA_I[TEST_WEN_BIT];
      end
    end
  end

  // test values, upper bits of the top register not implemented
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      for (int i = 0; i < 16; i++) begin
        test_mem[i] <= 8'h00;
      end
    end else if (wr_strb && addr_reg == REG_IDX_TEST_DATA &&
                 SPECIAL_MODE_I && test_wen_reg && IMASK_I) begin
      if (test_adr_reg == TEST_ADR_TOP) begin
        test_mem[test_adr_reg] <= HWDATA_I[7:0] & TEST_TOP_MASK;
      end else begin
        test_mem[test_adr_reg] <= HWDATA_I[7:0];
      end
    end
  end

  // ************************************************************
  // event interrupt
  // ************************************************************
  always_comb begin
    st_set = '0;
    st_set[ST_VEC_DONE] = vec_take;
    st_set[ST_PROM_REFUSED] = wr_strb && addr_reg == REG_IDX_PROMOTE &&
                              !IMASK_I;
    st_set[ST_FALLBACK] = vec_take && !rq.found;
  end

  // sticky status, set beats clear; enable register
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      st_reg <= ST_RST;
      en_reg <= ST_RST;
    end else begin
      if (wr_strb && addr_reg == REG_IDX_IRQ_CLEAR) begin
        st_reg <= (st_reg & ~HWDATA_I[ST_BITS-1:0]) | st_set;
      end else begin
        st_reg <= st_reg | st_set;
      end
      if (wr_strb && addr_reg == REG_IDX_IRQ_ENABLE) begin
        en_reg <= HWDATA_I[ST_BITS-1:0];
      end
    end
  end

  // level interrupt from flop
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |((st_reg | st_set) & en_reg);
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);

  property p_vec_answer;
    vec_take |=> VEC_VALID_O && VEC_O == $past(sel_vec);
  endproperty
  a_vec_answer: assert property (p_vec_answer)
    else $error("vector not returned one cycle after the strobe");

  property p_vec_hold;
    VEC_VALID_O && VEC_REQ_I |=> VEC_VALID_O && $stable(VEC_O);
  endproperty
  a_vec_hold: assert property (p_vec_hold)
    else $error("vector changed while the strobe stayed high");

  property p_sys_reset_top;
    vec_take && rq.req[IDX_SYS] |=> VEC_O == 16'hFFFE;
  endproperty
  a_sys_reset_top: assert property (p_sys_reset_top)
    else $error("system reset did not win the vector");

  property p_swi_default;
    vec_take && !rq.found && !ever_reg |=> VEC_O == 16'hFFF6;
  endproperty
  a_swi_default: assert property (p_swi_default)
    else $error("idle vector request did not return software trap");

  property p_last_valid;
    vec_take && !rq.found && ever_reg |=>
      VEC_O == evpu_vec_addr($past(last_reg));
  endproperty
  a_last_valid: assert property (p_last_valid)
    else $error("vanished source did not return the last valid vector");

  property p_promoted;
    vec_take && rq.found && rq.idx <= IDX_IRQ && rq.req[prom_eff] |=>
      VEC_O[7:1] == $past(prom_eff);
  endproperty
  a_promoted: assert property (p_promoted)
    else $error("active promoted source lost to another maskable");

  property p_prom_range;
    prom_reg[7:1] > 7'h79 |-> prom_eff == 7'h79;
  endproperty
  a_prom_range: assert property (p_prom_range)
    else $error("out-of-range promotion did not fall back");

  property p_prom_lock;
    wr_strb && addr_reg == REG_IDX_PROMOTE && !IMASK_I |=>
      $stable(prom_reg) ##1 st_reg[ST_PROM_REFUSED];
  endproperty
  a_prom_lock: assert property (p_prom_lock)
    else $error("promotion write taken without the mask");

  property p_test_feed;
    test_wen_reg |-> rq.req[NUM_TESTABLE-1:0] == test_flat;
  endproperty
  a_test_feed: assert property (p_test_feed)
    else $error("decoder not fed from the test values");

  property p_test_normal_read;
    rd_pend_reg && addr_reg == REG_IDX_TEST_DATA && !SPECIAL_MODE_I |=>
      HRDATA_O == 32'h0000_0000 && HREADYOUT_O;
  endproperty
  a_test_normal_read: assert property (p_test_normal_read)
    else $error("test data readable outside special mode");

  property p_wake_nmi;
    !NMI_N_I |-> WAKEUP_O;
  endproperty
  a_wake_nmi: assert property (p_wake_nmi)
    else $error("non-maskable pin request did not raise wake-up");

  c_promoted: cover property (vec_take && rq.found && rq.idx == prom_eff
                              && prom_eff != IDX_IRQ);
  c_fallback: cover property (vec_take && !rq.found && ever_reg);
  c_test_mode: cover property (test_wen_reg && vec_take && rq.found);
  c_irq_out: cover property ($rose(IRQ_O));

endmodule : evpu_top

// ### tb/evpu_cpu_model.sv
/* cpu side model: raises the vector strobe on a start pulse, holds it
   until the vector is seen valid, then keeps the vector it took.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/10ps
module evpu_cpu_model (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic start_i,
  input wire logic vec_valid_i,
  input wire logic [15:0] vec_i,
  output logic vec_req_o,
  output logic done_o,
  output logic [15:0] vec_seen_o
);
  // ****************************************
  // strobe handshake
  // ****************************************
  // strobe held until valid is sampled, vector taken at that edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      vec_req_o <= 1'b0;
      done_o <= 1'b0;
      vec_seen_o <= 16'h0000;
    end else if (start_i) begin
      vec_req_o <= 1'b1;
      done_o <= 1'b0;
    end else if (vec_req_o && vec_valid_i) begin
      vec_seen_o <= vec_i;
      vec_req_o <= 1'b0;
      done_o <= 1'b1;
    end
  end
endmodule : evpu_cpu_model

// ### tb/evpu_top_tb.sv
/* self-checking bench of the exception vector unit: bus and vector
   request tasks, then sequences of calls with expected values.
   Assumes the cpu model file is compiled before this one. */
`timescale 1ns/10ps
module evpu_top_tb
  import evpu_pkg::*;
;
  logic CLK_I, SRST_I, HSEL_I, HWRITE_I, HREADY_I, HRESP_O, HREADYOUT_O;
  logic [31:0] HADDR_I, HWDATA_I, HRDATA_O;
  logic [1:0] HTRANS_I;
  logic [2:0] HSIZE_I;
  logic IMASK_I, XMASK_I, SPECIAL_MODE_I, VEC_REQ_I, VEC_VALID_O;
  logic WAKEUP_O, IRQ_O, start, done;
  logic [15:0] VEC_O, seen;
  logic [8:0] act;
  logic [120:0] pr;
  int failures, num_checks, cycles;
  logic [15:0] pri [9] = '{16'hFFFE, 16'hFFFC, 16'hFFFA, 16'hFFF8,
    16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFF0, 16'hFF00};

  // source map: resets, trap, software, pins, two peripherals
  assign HREADY_I = HREADYOUT_O;
  evpu_top u_evpu_top (.CLK_I(CLK_I), .SRST_I(SRST_I), .HSEL_I(HSEL_I),
    .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
    .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I),
    .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
    .RST_SYS_I(act[8]), .RST_OSC_I(act[7]), .RST_WDOG_I(act[6]),
    .TRAP_I(act[5]), .SWI_I(act[4]), .NMI_N_I(~act[3]),
    .IRQ_N_I(~act[2]), .PERIPH_REQ_I(pr | {act[1], 119'h0, act[0]}),
    .IMASK_I(IMASK_I), .XMASK_I(XMASK_I), .SPECIAL_MODE_I(SPECIAL_MODE_I),
    .VEC_REQ_I(VEC_REQ_I), .VEC_O(VEC_O), .VEC_VALID_O(VEC_VALID_O),
    .WAKEUP_O(WAKEUP_O), .IRQ_O(IRQ_O));
  evpu_cpu_model u_evpu_cpu_model (.clk_i(CLK_I), .srst_i(SRST_I),
    .start_i(start), .vec_valid_i(VEC_VALID_O), .vec_i(VEC_O),
    .vec_req_o(VEC_REQ_I), .done_o(done), .vec_seen_o(seen));

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : check

  // one single word transfer, address phase held until hready
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    HSEL_I <= 1'b1;
    HTRANS_I <= 2'h2;
    HADDR_I <= {24'h000000, a};
    HWRITE_I <= w;
    do @(posedge CLK_I); while (HREADYOUT_O !== 1'b1);
    HSEL_I <= 1'b0;
    HTRANS_I <= 2'h0;
    HWDATA_I <= d;
    do @(posedge CLK_I); while (HREADYOUT_O !== 1'b1);
    r = HRDATA_O;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h00000000, r);
    check(r, e);
    check({31'h0, HRESP_O}, 32'h0);
  endtask : rd

  // vector request through the cpu model
  task automatic vec(input logic [15:0] e);
    start <= 1'b1;
    @(posedge CLK_I);
    start <= 1'b0;
    do @(posedge CLK_I); while (done !== 1'b1);
    check({16'h0000, seen}, {16'h0000, e});
    repeat (2) @(posedge CLK_I);
  endtask : vec

  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  // ****************************************
  // clock, timeout
  // ****************************************
  initial begin
    CLK_I = 1'b0;
    forever #12.5 CLK_I = ~CLK_I;
  end

  // hang guard
  always @(posedge CLK_I) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      conclude();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {HSEL_I, HWRITE_I, VEC_REQ_I, start} = 4'h0;
    {IMASK_I, XMASK_I, SPECIAL_MODE_I} = 3'h0;
    {HADDR_I, HWDATA_I, HTRANS_I, HSIZE_I} = {64'h0, 2'h0, 3'h2};
    act = 9'h000;
    pr = '0;
    {failures, num_checks, cycles} = {32'h0, 32'h0, 32'h0};
    SRST_I = 1'b1;
    repeat (12) @(posedge CLK_I);
    SRST_I <= 1'b0;
    @(posedge CLK_I);
    vec(16'hFFF6);
    rd(8'h7C, 32'h000000F2);
    check({31'h0, WAKEUP_O}, 32'h0);
    act <= 9'h1FF;
    repeat (6) @(posedge CLK_I);
    check({31'h0, WAKEUP_O}, 32'h1);
    // sources held until served, then dropped highest first
    for (int i = 8; i >= 0; i--) begin
      vec(pri[8-i]);
      act[i] <= 1'b0;
      repeat (6) @(posedge CLK_I);
    end
    vec(16'hFF00);
    rd(8'h80, 32'h00000005);
    wr(8'h88, 32'h00000001);
    repeat (2) @(posedge CLK_I);
    check({31'h0, IRQ_O}, 32'h1);
    wr(8'h84, 32'h00000007);
    rd(8'h80, 32'h00000000);
    check({31'h0, IRQ_O}, 32'h0);
    // promotion: refused unmasked, taken masked
    wr(8'h7C, 32'h00000002);
    rd(8'h7C, 32'h000000F2);
    rd(8'h80, 32'h00000002);
    check({31'h0, IRQ_O}, 32'h0);
    IMASK_I <= 1'b1;
    wr(8'h7C, 32'h00000002);
    rd(8'h7C, 32'h00000002);
    IMASK_I <= 1'b0;
    pr[1] <= 1'b1;
    pr[2] <= 1'b1;
    pr[IDX_RTI] <= 1'b1;
    repeat (2) @(posedge CLK_I);
    vec(16'hFF02);
    pr[1] <= 1'b0;
    repeat (2) @(posedge CLK_I);
    vec(16'hFF04);
    IMASK_I <= 1'b1;
    wr(8'h7C, 32'h000000FE);
    IMASK_I <= 1'b0;
    pr[1] <= 1'b1;
    repeat (2) @(posedge CLK_I);
    vec({8'hFF, IDX_RTI, 1'b0});
    act[2] <= 1'b1;
    repeat (6) @(posedge CLK_I);
    vec(16'hFFF2);
    // non-maskable pin masked: maskable pin wins
    XMASK_I <= 1'b1;
    act[3] <= 1'b1;
    repeat (6) @(posedge CLK_I);
    vec(16'hFFF2);
    XMASK_I <= 1'b0;
    act <= 9'h001;
    pr <= '0;
    repeat (6) @(posedge CLK_I);
    // test registers in normal and special mode
    rd(8'h58, 32'h00000000);
    SPECIAL_MODE_I <= 1'b1;
    IMASK_I <= 1'b1;
    XMASK_I <= 1'b1;
    wr(8'h54, 32'h00000000);
    rd(8'h58, 32'h00000001);
    wr(8'h54, 32'h00000010);
    wr(8'h58, 32'h00000004);
    IMASK_I <= 1'b0;
    repeat (2) @(posedge CLK_I);
    vec(16'hFF04);
    rd(8'h40, 32'h00000000);
    conclude();
  end
endmodule : evpu_top_tb
